// ### logic/rtcxb_pkg.sv
package rtcxb_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_SHARED_END     = 8'h3f;
  localparam logic [7:0] IDX_WAKE_CTRL1     = 8'h40;
  localparam logic [7:0] IDX_WAKE_CTRL2     = 8'h41;
  localparam logic [7:0] IDX_WAKE_STATUS    = 8'h42;
  localparam logic [7:0] IDX_WAKE_DOW       = 8'h43;
  localparam logic [7:0] IDX_WAKE_DATE      = 8'h44;
  localparam logic [7:0] IDX_WAKE_MONTH     = 8'h45;
  localparam logic [7:0] IDX_WAKE_YEAR      = 8'h46;
  localparam logic [7:0] IDX_RAM_LOCK       = 8'h47;
  localparam logic [7:0] IDX_CENTURY        = 8'h48;
  localparam logic [7:0] IDX_RSVD1_END      = 8'h47;
  localparam logic [7:0] IDX_UPPER_PTR      = 8'h50;
  localparam logic [7:0] IDX_UPPER_WINDOW   = 8'h53;
  localparam logic [7:0] IDX_BANK_SELECT    = 8'h80;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h81;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'h82;
  // Bank numbers
  localparam logic [1:0] BANK_GENERAL       = 2'h0;
  localparam logic [1:0] BANK_CLOCK         = 2'h1;
  localparam logic [1:0] BANK_WAKE          = 2'h2;
  // Reset values
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [6:0] RST_WAKE_STATUS    = 7'h41;
  localparam logic [7:0] READ_BLOCKED       = 8'hff;
  // Lock register fields
  localparam int LOCK_UPPER_BLOCK           = 3;
  localparam int LOCK_BLOCK_READ            = 4;
  localparam int LOCK_BLOCK_WRITE           = 5;
  localparam int LOCK_MASK_WRITE            = 6;
  localparam int LOCK_RAM                   = 7;
  localparam logic [7:0] LOCK_USED_BITS     = 8'hf8;
  localparam logic [2:0] LOCKED_ROW         = 3'h7;
  localparam logic [6:0] UPPER_BLOCK_LIMIT  = 7'h20;
  localparam int EVENT_BITS                 = 6;
endpackage

// ### logic/rtcxb_ram.sv
`timescale 1ns/1ps
`default_nettype none
module rtcxb_ram
  import rtcxb_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 8
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Write port
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Read port, registered
  input  wire logic [ADDR_W-1:0] raddr_i,
  output var  logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Array has no reset; battery-backed content is not initialised
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// ### logic/rtcxb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rtcxb_regs
  import rtcxb_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Clock core side
  input  wire logic        MASTER_RESET_PIN_I,
  input  wire logic [5:0]  WAKE_EVENT_I,
  input  wire logic        RING_STATUS_I,
  output var  logic [7:0]  WAKE_CONTROL_FIRST_O,
  output var  logic [7:0]  WAKE_CONTROL_SECOND_O,
  output var  logic [7:0]  RAM_ACCESS_LOCK_O,
  // Interrupt
  output var  logic        IRQ_O
);
  logic [7:0] idx;
  logic       addr_err;
  logic       is_shared;
  logic       lock_hit;
  logic       low_upper;
  logic       window_lock;
  logic       access_done;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] wbyte;
  logic [7:0] next_rdata;
  logic [1:0] bank_select;
  logic [7:0] calendar_century;
  logic [7:0] wake_century;
  logic [6:0] upper_ram_pointer;
  logic [7:0] wake_day_of_week;
  logic [7:0] wake_date_of_month;
  logic [7:0] wake_month;
  logic [7:0] wake_year;
  logic [6:0] wake_event_status;
  logic [5:0] irq_status;
  logic [5:0] irq_mask;
  logic [7:0] shared_rd;
  logic [7:0] general_rd;
  logic [7:0] upper_rd;
  logic       shared_we;
  logic       general_we;
  logic       upper_we;

  // Decode
  assign idx         = PADDR[9:2];
  assign addr_err    = (PADDR[11:10] != 2'h0) || (idx > IDX_IRQ_MASK);
  assign is_shared   = (idx <= IDX_SHARED_END);
  assign lock_hit    = is_shared && (idx[5:3] == LOCKED_ROW)
                       && RAM_ACCESS_LOCK_O[LOCK_RAM];
  assign low_upper   = (upper_ram_pointer < UPPER_BLOCK_LIMIT);
  assign window_lock = RAM_ACCESS_LOCK_O[LOCK_UPPER_BLOCK]
                       || (RAM_ACCESS_LOCK_O[LOCK_BLOCK_READ] && low_upper);
  assign access_done = PSEL && PENABLE && PREADY;
  assign wr_done     = access_done && PWRITE && !addr_err;
  assign rd_done     = PSEL && PENABLE && !PREADY && !PWRITE && !addr_err;
  assign wbyte       = PWDATA[7:0];

  // Two-cycle access phase: memories deliver registered data first
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && addr_err;
    end
  end

  // Read mux
  always_comb
  begin
    next_rdata = RST_ZERO;
    if (idx[7])
    begin
      case (idx)
        IDX_BANK_SELECT: next_rdata = {6'h00, bank_select};
        IDX_IRQ_STATUS:  next_rdata = {2'h0, irq_status};
        IDX_IRQ_MASK:    next_rdata = {2'h0, irq_mask};
        default:         next_rdata = RST_ZERO;
      endcase
    end
    else if (is_shared)
    begin
      next_rdata = lock_hit ? READ_BLOCKED : shared_rd;
    end
    else
    begin
      case (bank_select)
        BANK_GENERAL: next_rdata = general_rd;
        BANK_CLOCK:
        begin
          case (idx)
            IDX_CENTURY:   next_rdata = calendar_century;
            IDX_UPPER_PTR: next_rdata = {1'b0, upper_ram_pointer};
            IDX_UPPER_WINDOW: next_rdata = window_lock ? READ_BLOCKED : upper_rd;
            default:       next_rdata = RST_ZERO;
          endcase
        end
        BANK_WAKE:
        begin
          case (idx)
            IDX_WAKE_CTRL1:  next_rdata = WAKE_CONTROL_FIRST_O;
            IDX_WAKE_CTRL2:  next_rdata = WAKE_CONTROL_SECOND_O;
            IDX_WAKE_STATUS: next_rdata = {RING_STATUS_I, wake_event_status};
            IDX_WAKE_DOW:    next_rdata = wake_day_of_week;
            IDX_WAKE_DATE:   next_rdata = wake_date_of_month;
            IDX_WAKE_MONTH:  next_rdata = wake_month;
            IDX_WAKE_YEAR:   next_rdata = wake_year;
            IDX_RAM_LOCK:    next_rdata = RAM_ACCESS_LOCK_O;
            IDX_CENTURY:     next_rdata = wake_century;
            default:         next_rdata = RST_ZERO;
          endcase
        end
        default: next_rdata = RST_ZERO;
      endcase
    end
  end

  // Read data captured in the cycle PREADY rises
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      PRDATA <= 32'h0000_0000;
    end
    else if (PSEL && PENABLE && !PREADY && !PWRITE)
    begin
      PRDATA <= addr_err ? 32'h0000_0000 : {24'h00_0000, next_rdata};
    end
  end

  // Storage write enables; mask-write lock covers all RAM
  assign shared_we  = wr_done && is_shared && !lock_hit
                      && !RAM_ACCESS_LOCK_O[LOCK_MASK_WRITE];
  assign general_we = wr_done && !is_shared && !idx[7] && (bank_select == BANK_GENERAL)
                      && !RAM_ACCESS_LOCK_O[LOCK_MASK_WRITE];
  assign upper_we   = wr_done && (bank_select == BANK_CLOCK) && (idx == IDX_UPPER_WINDOW)
                      && !RAM_ACCESS_LOCK_O[LOCK_UPPER_BLOCK]
                      && !RAM_ACCESS_LOCK_O[LOCK_MASK_WRITE]
                      && !(RAM_ACCESS_LOCK_O[LOCK_BLOCK_WRITE] && low_upper);

  rtcxb_ram #(.ADDR_W(6), .DATA_W(8)) u_shared_ram (
    .clk_i   (REF_CLK_I),
    .nrst_i  (NRST_I),
    .we_i    (shared_we),
    .waddr_i (idx[5:0]),
    .wdata_i (wbyte),
    .raddr_i (idx[5:0]),
    .rdata_o (shared_rd)
  );

  rtcxb_ram #(.ADDR_W(6), .DATA_W(8)) u_general_ram (
    .clk_i   (REF_CLK_I),
    .nrst_i  (NRST_I),
    .we_i    (general_we),
    .waddr_i (idx[5:0]),
    .wdata_i (wbyte),
    .raddr_i (idx[5:0]),
    .rdata_o (general_rd)
  );

  rtcxb_ram #(.ADDR_W(7), .DATA_W(8)) u_upper_ram (
    .clk_i   (REF_CLK_I),
    .nrst_i  (NRST_I),
    .we_i    (upper_we),
    .waddr_i (upper_ram_pointer),
    .wdata_i (wbyte),
    .raddr_i (upper_ram_pointer),
    .rdata_o (upper_rd)
  );

  // Bank 1 registers and bank select
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      bank_select       <= BANK_GENERAL;
      calendar_century  <= RST_ZERO;
      upper_ram_pointer <= RST_ZERO[6:0];
    end
    else if (wr_done)
    begin
      if (idx == IDX_BANK_SELECT)
      begin
        bank_select <= wbyte[1:0];
      end
      if (bank_select == BANK_CLOCK && idx == IDX_CENTURY)
      begin
        calendar_century <= wbyte;
      end
      if (bank_select == BANK_CLOCK && idx == IDX_UPPER_PTR)
      begin
        upper_ram_pointer <= wbyte[6:0];
      end
    end
  end

  // Bank 2 control and wake calendar
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      WAKE_CONTROL_FIRST_O  <= RST_ZERO;
      WAKE_CONTROL_SECOND_O <= RST_ZERO;
      wake_day_of_week      <= RST_ZERO;
      wake_date_of_month    <= RST_ZERO;
      wake_month            <= RST_ZERO;
      wake_year             <= RST_ZERO;
      wake_century          <= RST_ZERO;
    end
    else if (wr_done && bank_select == BANK_WAKE)
    begin
      case (idx)
        IDX_WAKE_CTRL1: WAKE_CONTROL_FIRST_O  <= wbyte;
        IDX_WAKE_CTRL2: WAKE_CONTROL_SECOND_O <= wbyte;
        IDX_WAKE_DOW:   wake_day_of_week      <= wbyte;
        IDX_WAKE_DATE:  wake_date_of_month    <= wbyte;
        IDX_WAKE_MONTH: wake_month            <= wbyte;
        IDX_WAKE_YEAR:  wake_year             <= wbyte;
        IDX_CENTURY:    wake_century          <= wbyte;
        default:        wake_century          <= wake_century;
      endcase
    end
  end

  // Lock bits only accumulate; only NRST_I or the master reset pin clears them
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      RAM_ACCESS_LOCK_O <= RST_ZERO;
    end
    else if (MASTER_RESET_PIN_I)
    begin
      RAM_ACCESS_LOCK_O <= RST_ZERO;
    end
    else if (wr_done && bank_select == BANK_WAKE && idx == IDX_RAM_LOCK)
    begin
      RAM_ACCESS_LOCK_O <= RAM_ACCESS_LOCK_O | (wbyte & LOCK_USED_BITS);
    end
  end

  // Clear on the capture edge so no event slips in unread; set wins
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wake_event_status <= RST_WAKE_STATUS;
    end
    else if (rd_done && bank_select == BANK_WAKE && idx == IDX_WAKE_STATUS)
    begin
      wake_event_status[5:0] <= WAKE_EVENT_I;
    end
    else
    begin
      wake_event_status[5:0] <= wake_event_status[5:0] | WAKE_EVENT_I;
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      irq_status <= RST_ZERO[5:0];
      irq_mask   <= RST_ZERO[5:0];
      IRQ_O      <= 1'b0;
    end
    else
    begin
      if (rd_done && idx == IDX_IRQ_STATUS)
      begin
        irq_status <= WAKE_EVENT_I;
      end
      else
      begin
        irq_status <= irq_status | WAKE_EVENT_I;
      end
      if (wr_done && idx == IDX_IRQ_MASK)
      begin
        irq_mask <= wbyte[5:0];
      end
      IRQ_O <= |(irq_status & irq_mask);
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  a_rsvd_reads_zero: assert property (
    PREADY && PSEL && !PWRITE && bank_select == BANK_CLOCK
    && idx >= IDX_WAKE_CTRL1 && idx <= IDX_RSVD1_END |-> PRDATA == 32'h0000_0000)
    else $error("reserved bank 1 index read nonzero");
  a_century_write: assert property (
    wr_done && bank_select == BANK_CLOCK && idx == IDX_CENTURY
    |=> calendar_century == $past(PWDATA[7:0]))
    else $error("century write lost");
  a_lock_sticky: assert property (
    RAM_ACCESS_LOCK_O[LOCK_RAM] && !MASTER_RESET_PIN_I |=> RAM_ACCESS_LOCK_O[LOCK_RAM])
    else $error("lock bit fell without master reset");
  a_mr_clears_lock: assert property (
    MASTER_RESET_PIN_I |=> RAM_ACCESS_LOCK_O == 8'h00)
    else $error("master reset did not clear lock");
  a_locked_row_ff: assert property (
    rd_done && lock_hit |=> PRDATA == 32'h0000_00ff)
    else $error("locked row read not FFh");
  a_upper_block_ff: assert property (
    rd_done && bank_select == BANK_CLOCK && idx == IDX_UPPER_WINDOW
    && RAM_ACCESS_LOCK_O[LOCK_UPPER_BLOCK] |=> PRDATA == 32'h0000_00ff)
    else $error("blocked upper window read not FFh");
  a_status_clear: assert property (
    rd_done && bank_select == BANK_WAKE && idx == IDX_WAKE_STATUS && WAKE_EVENT_I == 6'h00
    |=> wake_event_status[5:0] == 6'h00)
    else $error("status read did not clear events");
  a_pointer_bank: assert property (
    wr_done && bank_select != BANK_CLOCK && idx == IDX_UPPER_PTR |=> $stable(upper_ram_pointer))
    else $error("pointer written outside bank 1");
  a_ready_timing: assert property (
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY)
    else $error("access phase not two cycles");
  a_irq_follow: assert property (
    |(irq_status & irq_mask) |-> ##[1:2] IRQ_O)
    else $error("interrupt not raised");

  c_upper_write: cover property (upper_we);
  c_lock_set: cover property (wr_done && idx == IDX_RAM_LOCK && bank_select == BANK_WAKE);
  c_status_clear: cover property (rd_done && idx == IDX_WAKE_STATUS && bank_select == BANK_WAKE);
  c_irq: cover property (IRQ_O);
endmodule
`default_nettype wire

// ### verification/rtcxb_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench
  import rtcxb_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mr_pin;
  logic [5:0]  wake_event;
  logic        ring;
  logic [7:0]  ctrl_first;
  logic [7:0]  ctrl_second;
  logic [7:0]  lock_out;
  logic        irq;
  int          failures;
  int          tests_run;
  logic [31:0] rdata;
  logic        err;

  rtcxb_regs uut (
    .REF_CLK_I             (clk),
    .NRST_I                (nrst),
    .PSEL                  (psel),
    .PENABLE               (penable),
    .PWRITE                (pwrite),
    .PADDR                 (paddr),
    .PWDATA                (pwdata),
    .PRDATA                (prdata),
    .PREADY                (pready),
    .PSLVERR               (pslverr),
    .MASTER_RESET_PIN_I    (mr_pin),
    .WAKE_EVENT_I          (wake_event),
    .RING_STATUS_I         (ring),
    .WAKE_CONTROL_FIRST_O  (ctrl_first),
    .WAKE_CONTROL_SECOND_O (ctrl_second),
    .RAM_ACCESS_LOCK_O     (lock_out),
    .IRQ_O                 (irq)
  );

  always #4 clk = ~clk;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      failures++;
      end_sim();
    end
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rdata, {24'h0, exp})
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; mr_pin = 1'b0; wake_event = 6'h00; ring = 1'b0;
    failures = 0;
    tests_run = 0;
    cycles(12);
    nrst <= 1'b1;
    // Reset values of the wake bank, read before any event
    wr(IDX_BANK_SELECT, {6'h0, BANK_WAKE});
    rd_chk(8'h40, 8'h00);
    rd_chk(8'h41, 8'h00);
    rd_chk(8'h47, 8'h00);
    rd_chk(8'h48, 8'h00);
    rd_chk(8'h42, 8'h41);
    rd_chk(8'h42, 8'h40);
    wr(8'h40, 8'h5a);
    wr(8'h41, 8'ha5);
    // Outputs update on the completion edge; look one edge later
    cycles(1);
    `CHK(ctrl_first, 8'h5a)
    `CHK(ctrl_second, 8'ha5)
    for (int i = 0; i < 4; i++)
      wr(8'h43 + 8'(i), 8'h01 + 8'(i));
    for (int i = 0; i < 4; i++)
      rd_chk(8'h43 + 8'(i), 8'h01 + 8'(i));
    wr(8'h42, 8'h3f);
    rd_chk(8'h42, 8'h40);
    wr(8'h48, 8'h20);
    wr(8'h49, 8'h44);
    rd_chk(8'h49, 8'h00);
    // Shared low area and per-bank decode
    wr(IDX_BANK_SELECT, {6'h0, BANK_GENERAL});
    wr(8'h20, 8'h77);
    wr(8'h38, 8'h3c);
    wr(IDX_BANK_SELECT, {6'h0, BANK_CLOCK});
    rd_chk(8'h20, 8'h77);
    rd_chk(8'h48, 8'h00);
    wr(8'h48, 8'h19);
    rd_chk(8'h48, 8'h19);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h40 + 8'(i), 8'hee);
      rd_chk(8'h40 + 8'(i), 8'h00);
    end
    wr(8'h49, 8'h33);
    rd_chk(8'h49, 8'h00);
    rd_chk(8'h54, 8'h00);
    // Indirect upper RAM through pointer and window
    wr(8'h50, 8'h05);
    wr(8'h53, 8'h5a);
    wr(8'h50, 8'h7f);
    wr(8'h53, 8'ha5);
    rd_chk(8'h50, 8'h7f);
    wr(8'h50, 8'h05);
    rd_chk(8'h53, 8'h5a);
    wr(8'h50, 8'h7f);
    rd_chk(8'h53, 8'ha5);
    wr(IDX_BANK_SELECT, {6'h0, BANK_WAKE});
    rd_chk(8'h20, 8'h77);
    rd_chk(8'h48, 8'h20);
    // Pointer index is reserved outside bank 1
    wr(8'h50, 8'h11);
    // Lock bits stick; reserved low bits never set
    wr(8'h47, 8'h8b);
    rd_chk(8'h47, 8'h88);
    wr(8'h47, 8'h00);
    rd_chk(8'h47, 8'h88);
    `CHK(lock_out, 8'h88)
    wr(8'h38, 8'h11);
    rd_chk(8'h38, 8'hff);
    wr(IDX_BANK_SELECT, {6'h0, BANK_CLOCK});
    rd_chk(8'h50, 8'h7f);
    rd_chk(8'h3f, 8'hff);
    wr(8'h53, 8'h00);
    rd_chk(8'h53, 8'hff);
    // Besides NRST_I, only the master reset pin releases the lock
    @(posedge clk);
    mr_pin <= 1'b1;
    cycles(2);
    mr_pin <= 1'b0;
    cycles(2);
    `CHK(lock_out, 8'h00)
    rd_chk(8'h38, 8'h3c);
    rd_chk(8'h53, 8'ha5);
    // Events: unmasked raises the interrupt, masked does not
    wr(IDX_IRQ_MASK, 8'h01);
    wake_event <= 6'h01;
    @(posedge clk);
    wake_event <= 6'h00;
    cycles(4);
    `CHK(irq, 1'b1)
    rd_chk(IDX_IRQ_STATUS, 8'h01);
    cycles(3);
    `CHK(irq, 1'b0)
    wake_event <= 6'h02;
    ring <= 1'b1;
    @(posedge clk);
    wake_event <= 6'h00;
    cycles(4);
    `CHK(irq, 1'b0)
    wr(IDX_BANK_SELECT, {6'h0, BANK_WAKE});
    rd_chk(8'h42, 8'hc3);
    rd_chk(8'h42, 8'hc0);
    // Unmapped index answers with an error and no data
    apb(1'b0, 8'h83, 8'h00);
    `CHK(err, 1'b1)
    `CHK(rdata, 32'h0)
    end_sim();
  end
endmodule
`default_nettype wire
